// ===== rtl/pdm_microphone_output.sv
/*
 * Output side of a one-bit density-modulated microphone: a fourth-order
 * modulator, half-cycle slot driver on a shared data line, clock-activity
 * sleep detector and start-up counter.
 * Assumes the audio word arrives on the system clock and that the host
 * owns the link clock; the pad merges data and enable into the wire.
 */
`timescale 1ns/1ps

module pdm_microphone_output #(
	parameter int SLEEP_CYC = pdm_mic_pkg::SLEEP_CYCLES,
	parameter int WAKE_CYC  = pdm_mic_pkg::WAKE_CYCLES
) (
	// System
	input  wire logic                              sys_clk_i,
	input  wire logic                              arst_n_i,
	// Link pins
	input  wire logic                              pdm_clk_i,
	input  wire logic                              chan_sel_i,
	output logic                                   pdm_data_o,
	output logic                                   pdm_data_oe_o,
	// Front end and status
	input  wire logic [pdm_mic_pkg::SAMPLE_W-1:0] audio_i,
	output logic                                   asleep_o
);

	localparam int AW = pdm_mic_pkg::ACC_W;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [pdm_mic_pkg::SYNC_STAGES-1:0] clk_sync;
	logic [pdm_mic_pkg::SYNC_STAGES-1:0] sel_sync;
	logic [pdm_mic_pkg::SYNC_STAGES-1:0] next_clk_sync;
	logic [pdm_mic_pkg::SYNC_STAGES-1:0] next_sel_sync;
	logic                                clk_rise;
	logic                                clk_fall;

	// Shift in; stage 0 feeds only stage 1
	always_comb begin
		next_clk_sync = {clk_sync[1:0], pdm_clk_i};
		next_sel_sync = {sel_sync[1:0], chan_sel_i};
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			clk_sync <= '0;
			sel_sync <= '0;
		end else begin
			clk_sync <= next_clk_sync;
			sel_sync <= next_sel_sync;
		end
	end

	// Edges seen once stages two and three disagree
	assign clk_rise = clk_sync[1] & ~clk_sync[2];
	assign clk_fall = ~clk_sync[1] & clk_sync[2];

	// ------------------------------------------------------------
	// Activity, start-up and channel strap
	// ------------------------------------------------------------
	pdm_mic_pkg::state_e                 state;
	pdm_mic_pkg::state_e                 next_state;
	logic [pdm_mic_pkg::IDLE_W-1:0]      idle_cnt;
	logic [pdm_mic_pkg::IDLE_W-1:0]      next_idle_cnt;
	logic [pdm_mic_pkg::WAKE_W-1:0]      wake_cnt;
	logic [pdm_mic_pkg::WAKE_W-1:0]      next_wake_cnt;
	logic                                chan_left;
	logic                                next_chan_left;
	logic                                idle_out;

	// Gap measured between rising edges: a period above 1 ms trips it
	assign idle_out = (idle_cnt == pdm_mic_pkg::IDLE_W'(SLEEP_CYC - 1)) && !clk_rise;

	always_comb begin
		next_state     = state;
		next_wake_cnt  = wake_cnt;
		next_idle_cnt  = idle_cnt;
		next_chan_left = chan_left;
		// Strap taken once the last two stages agree
		if (sel_sync[1] == sel_sync[2]) begin
			next_chan_left = (sel_sync[2] == pdm_mic_pkg::SEL_LEFT);
		end
		if (clk_rise) begin
			next_idle_cnt = '0;
		end else if (!idle_out) begin
			next_idle_cnt = idle_cnt + 1'b1;
		end
		unique case (state)
			pdm_mic_pkg::ST_SLEEP: begin
				// First edge after a stop counts as cycle one
				if (clk_rise) begin
					next_state    = pdm_mic_pkg::ST_WAKE;
					next_wake_cnt = pdm_mic_pkg::WAKE_W'(1);
				end
			end
			pdm_mic_pkg::ST_WAKE: begin
				if (idle_out) begin
					next_state    = pdm_mic_pkg::ST_SLEEP;
					next_wake_cnt = '0;
				end else if (clk_rise) begin
					if (wake_cnt == pdm_mic_pkg::WAKE_W'(WAKE_CYC - 1)) begin
						next_state    = pdm_mic_pkg::ST_RUN;
						next_wake_cnt = '0;
					end else begin
						next_wake_cnt = wake_cnt + 1'b1;
					end
				end
			end
			pdm_mic_pkg::ST_RUN: begin
				if (idle_out) begin
					next_state = pdm_mic_pkg::ST_SLEEP;
				end
			end
		endcase
	end

	// Reset lands in sleep so power-up waits for clock activity
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state     <= pdm_mic_pkg::ST_SLEEP;
			idle_cnt  <= '0;
			wake_cnt  <= '0;
			chan_left <= 1'b0;
		end else begin
			state     <= next_state;
			idle_cnt  <= next_idle_cnt;
			wake_cnt  <= next_wake_cnt;
			chan_left <= next_chan_left;
		end
	end

	// ------------------------------------------------------------
	// Fourth-order modulator
	// ------------------------------------------------------------
	localparam logic [AW-1:0] FB_LAST = 24'h00_6800; // 13/16 of full scale
	logic [AW-1:0] acc      [pdm_mic_pkg::ORDER];
	logic [AW-1:0] next_acc [pdm_mic_pkg::ORDER];
	logic [AW-1:0] fb_step  [pdm_mic_pkg::ORDER];
	logic [AW-1:0] stage_in [pdm_mic_pkg::ORDER];
	logic          mod_bit;
	logic          launch;
	logic          release_edge;

	// Saturating add keeps a large input from wrapping the loop
	function automatic logic [AW-1:0] sat_add(input logic [AW-1:0] a, input logic [AW-1:0] b);
		logic [AW:0] s;
		s = {a[AW-1], a} + {b[AW-1], b};
		if ($signed(s) > $signed({1'b0, pdm_mic_pkg::ACC_MAX})) begin
			return pdm_mic_pkg::ACC_MAX;
		end
		if ($signed(s) < $signed({1'b1, pdm_mic_pkg::ACC_MIN})) begin
			return pdm_mic_pkg::ACC_MIN;
		end
		return s[AW-1:0];
	endfunction

	// Own half starts at the rising edge for left, falling for right
	assign launch       = chan_left ? clk_rise : clk_fall;
	assign release_edge = chan_left ? clk_fall : clk_rise;
	assign mod_bit      = ~acc[pdm_mic_pkg::ORDER-1][AW-1];

	// Gains 1/16, 1/8, 1/4 between stages put all four noise poles near 0.8;
	// equal gains with full feedback into every stage would make the loop oscillate
	assign stage_in[0] = {{(AW - pdm_mic_pkg::SAMPLE_W){audio_i[pdm_mic_pkg::SAMPLE_W-1]}}, audio_i};
	assign fb_step[0]  = mod_bit ? pdm_mic_pkg::FULL_SCALE : -pdm_mic_pkg::FULL_SCALE;
	generate
		for (genvar k = 1; k < pdm_mic_pkg::ORDER; k++) begin : g_stage
			localparam int            SH = (k == 1) ? 4 : (k == 2) ? 3 : 2;
			localparam logic [AW-1:0] FB = (k == pdm_mic_pkg::ORDER - 1) ? FB_LAST : pdm_mic_pkg::FULL_SCALE;
			assign stage_in[k] = {{SH{acc[k-1][AW-1]}}, acc[k-1][AW-1:SH]};
			assign fb_step[k]  = mod_bit ? FB : -FB;
		end
	endgenerate

	// One step per launched bit; zero input averages one bit in two
	always_comb begin
		for (int k = 0; k < pdm_mic_pkg::ORDER; k++) begin
			next_acc[k] = acc[k];
			if (launch) begin
				next_acc[k] = sat_add(acc[k], sat_add(stage_in[k], -fb_step[k]));
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int k = 0; k < pdm_mic_pkg::ORDER; k++) begin
				acc[k] <= '0;
			end
		end else begin
			for (int k = 0; k < pdm_mic_pkg::ORDER; k++) begin
				acc[k] <= next_acc[k];
			end
		end
	end

	// ------------------------------------------------------------
	// Slot driver
	// ------------------------------------------------------------
	logic next_data;
	logic next_oe;

	// Data moves only at launch; held level survives release
	always_comb begin
		next_data = pdm_data_o;
		next_oe   = pdm_data_oe_o;
		if (launch) begin
			next_data = mod_bit;
		end
		if (state != pdm_mic_pkg::ST_RUN || next_state != pdm_mic_pkg::ST_RUN) begin
			next_oe = 1'b0;
		end else if (launch) begin
			next_oe = 1'b1;
		end else if (release_edge) begin
			next_oe = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pdm_data_o    <= 1'b0;
			pdm_data_oe_o <= 1'b0;
			asleep_o      <= 1'b1;
		end else begin
			pdm_data_o    <= next_data;
			pdm_data_oe_o <= next_oe;
			asleep_o      <= (next_state == pdm_mic_pkg::ST_SLEEP);
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_sleep_hiz: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(state != pdm_mic_pkg::ST_RUN) |=> !pdm_data_oe_o)
		else $error("data driven outside run state");

	a_left_drive: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(state == pdm_mic_pkg::ST_RUN && next_state == pdm_mic_pkg::ST_RUN && chan_left && clk_rise)
		|=> pdm_data_oe_o && pdm_data_o == $past(mod_bit))
		else $error("left bit not launched at rising edge");

	a_right_drive: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(state == pdm_mic_pkg::ST_RUN && next_state == pdm_mic_pkg::ST_RUN && !chan_left && clk_fall)
		|=> pdm_data_oe_o && pdm_data_o == $past(mod_bit))
		else $error("right bit not launched at falling edge");

	a_half_release: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		release_edge |=> !pdm_data_oe_o)
		else $error("line not released in other half");

	a_one_edge: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		$changed(pdm_data_o) |-> $past(launch))
		else $error("data changed away from launch edge");

	a_strap_map: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(sel_sync[1] == sel_sync[2]) |=> chan_left == $past(sel_sync[2]))
		else $error("channel strap mapped wrongly");

	a_sleep_entry: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(state != pdm_mic_pkg::ST_SLEEP && idle_cnt == pdm_mic_pkg::IDLE_W'(SLEEP_CYC - 1) && !clk_rise)
		|=> state == pdm_mic_pkg::ST_SLEEP && asleep_o)
		else $error("no sleep after idle timeout");

	a_wake_done: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(state == pdm_mic_pkg::ST_WAKE && clk_rise && !idle_out
		 && wake_cnt == pdm_mic_pkg::WAKE_W'(WAKE_CYC - 1))
		|=> state == pdm_mic_pkg::ST_RUN && !asleep_o)
		else $error("run not entered at end of start-up count");

	a_wake_early: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(state == pdm_mic_pkg::ST_WAKE && wake_cnt != pdm_mic_pkg::WAKE_W'(WAKE_CYC - 1))
		|=> state != pdm_mic_pkg::ST_RUN)
		else $error("run entered before start-up count ended");

	a_wake_restart: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(state == pdm_mic_pkg::ST_WAKE && idle_out)
		|=> state == pdm_mic_pkg::ST_SLEEP && wake_cnt == '0 ##1 !pdm_data_oe_o)
		else $error("start-up count not restarted after stop");

endmodule

// ===== shared/pdm_mic_pkg.sv
/*
 * Constants for the microphone's one-bit output block: timing counts,
 * modulator sizes and the state encoding.
 * Assumes a 100 MHz system clock sampling the link clock pin.
 */
package pdm_mic_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int SYS_CLK_HZ    = 100_000_000;
	localparam int SLEEP_TIME_US = 1000;
	// Longest time, rounded down
	localparam int SLEEP_CYCLES  = (SYS_CLK_HZ / 1_000_000) * SLEEP_TIME_US;
	localparam int IDLE_W        = 17;
	localparam int WAKE_CYCLES   = 32768;
	localparam int WAKE_W        = 15;
	localparam int SYNC_STAGES   = 3;

	// ------------------------------------------------------------
	// Modulator
	// ------------------------------------------------------------
	localparam int              SAMPLE_W   = 16;
	localparam int              ACC_W      = 24;
	localparam logic [ACC_W-1:0] FULL_SCALE = 24'h00_8000;
	localparam logic [ACC_W-1:0] ACC_MAX    = 24'h3F_FFFF;
	localparam logic [ACC_W-1:0] ACC_MIN    = 24'hC0_0000;
	localparam int              ORDER      = 4;

	// ------------------------------------------------------------
	// Channel strap and states
	// ------------------------------------------------------------
	localparam logic SEL_LEFT = 1'b1;

	typedef enum logic [2:0] {
		ST_SLEEP = 3'b001,
		ST_WAKE  = 3'b010,
		ST_RUN   = 3'b100
	} state_e;

endpackage

// ===== dv/pdm_host_model.sv
/*
 * Host side of the one-bit link: makes the bit clock and tallies both slots.
 * Assumes the bench starts and stops the clock through go_i.
 */
`timescale 1ns/1ps
module pdm_host_model (
	// Control
	input  wire logic go_i,
	input  wire logic clr_i,
	// Link
	output logic      pdm_clk_o,
	input  wire logic data_i,
	input  wire logic oe_i,
	// Tallies
	output int        l_drv_o,
	output int        r_drv_o,
	output int        l_one_o
);
	logic line;
	logic last;

	// ----------------------------------------
	// Clock, 80 ns period, low when stopped
	// ----------------------------------------
	// Faster than a real host to keep runs short; the start-up counter counts edges, not time
	initial begin
		pdm_clk_o = 1'b0;
		#3;
		forever begin
			#40;
			pdm_clk_o = go_i ? ~pdm_clk_o : 1'b0;
		end
	end

	// No keeper: a released line shows the inverse of its last level
	always @(data_i or oe_i) begin
		if (oe_i) begin
			last = data_i;
		end
	end
	assign line = oe_i ? data_i : ~last;

	// ----------------------------------------
	// Slot sampling
	// ----------------------------------------
	// 10 ns into each half, clear of both launch and release
	always @(negedge pdm_clk_o) begin
		#10;
		l_drv_o += int'(oe_i);
		l_one_o += int'(oe_i & line);
	end
	always @(posedge pdm_clk_o) begin
		#10;
		r_drv_o += int'(oe_i);
	end
	always @(posedge clr_i) begin
		l_drv_o = 0;
		r_drv_o = 0;
		l_one_o = 0;
	end
endmodule

// ===== dv/testbench.sv
/*
 * Self-checking bench for the microphone output block.
 * Assumes the host model drives the link clock and counts slot samples.
 */
`timescale 1ns/1ps
module testbench;
	localparam int SLEEP = 200;
	localparam int WAKE  = 16;
	logic        sys_clk_i;
	logic        arst_n_i;
	logic        chan_sel_i;
	logic [15:0] audio_i;
	logic        pdm_clk;
	logic        pdm_data;
	logic        pdm_oe;
	logic        asleep;
	logic        go;
	logic        clr;
	int          l_drv;
	int          r_drv;
	int          l_one;
	int          n_errors;
	int          checks_done;

	pdm_microphone_output #(.SLEEP_CYC(SLEEP), .WAKE_CYC(WAKE)) uut (
		.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .pdm_clk_i(pdm_clk),
		.chan_sel_i(chan_sel_i), .pdm_data_o(pdm_data), .pdm_data_oe_o(pdm_oe),
		.audio_i(audio_i), .asleep_o(asleep));
	pdm_host_model host (
		.go_i(go), .clr_i(clr), .pdm_clk_o(pdm_clk), .data_i(pdm_data),
		.oe_i(pdm_oe), .l_drv_o(l_drv), .r_drv_o(r_drv), .l_one_o(l_one));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %0h exp %0h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Clock stops after the n-th falling edge
	task automatic run(input int n);
		go = 1'b1;
		repeat (n) @(negedge pdm_clk);
		go = 1'b0;
		#20;
	endtask

	task automatic fresh(input int n);
		clr = 1'b1;
		#1;
		clr = 1'b0;
		run(n);
	endtask

	task automatic drive(input logic sel, input logic [15:0] v);
		@(posedge sys_clk_i);
		#1;
		chan_sel_i = sel;
		audio_i = v;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Idle link: sleep near SLEEP cycles after the last rise
	task automatic t_sleep();
		int n;
		n = 0;
		while (asleep !== 1'b1 && n < 2 * SLEEP) begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end
		if (n >= 2 * SLEEP) begin
			n_errors++;
			finish_test();
		end
		check(32'(n > SLEEP - 20 && n <= SLEEP + 2), 1);
		check(pdm_oe, 0);
	endtask

	// Cut start-up short first to show the count restarts
	task automatic t_wake(input bit cut);
		drive(1'b1, 16'h0000);
		if (cut) begin
			run(WAKE / 2);
			t_sleep();
		end
		fresh(WAKE);
		check(l_drv, 0);
		check(asleep, 0);
		fresh(2);
		check(l_drv, 2);
	endtask

	task automatic t_slot(input logic sel);
		drive(sel, audio_i);
		run(4);
		fresh(32);
		check(l_drv, sel ? 32 : 0);
		check(r_drv, sel ? 0 : 32);
	endtask

	// Long settling run lets the integrators reach the new level first;
	// the window leaves room for 6 to 10 bits of offset in 64
	task automatic t_dens(input logic [15:0] v, input int lo, input int hi);
		drive(1'b1, v);
		run(64);
		fresh(64);
		check(32'(l_one >= lo && l_one <= hi), 1);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// A hang counts as a mismatch
	initial begin
		#500us;
		n_errors++;
		finish_test();
	end

	initial begin
		arst_n_i = 1'b0;
		chan_sel_i = 1'b1;
		audio_i = 16'h0000;
		go = 1'b0;
		clr = 1'b0;
		n_errors = 0;
		checks_done = 0;
		repeat (16) @(posedge sys_clk_i);
		#1;
		arst_n_i = 1'b1;
		check(asleep, 1);
		check(pdm_oe, 0);
		t_wake(1'b0);
		t_slot(1'b1);
		t_dens(16'h0000, 26, 38);
		t_dens(16'h4000, 42, 58);
		t_dens(16'hC000, 6, 22);
		t_slot(1'b0);
		// Right slot holds the line while the clock is stopped; launch lags the edge
		repeat (3) @(posedge sys_clk_i);
		#1;
		check(pdm_oe, 1);
		t_sleep();
		t_wake(1'b1);
		finish_test();
	end
endmodule
